// *** dfb_consts.svh ***
// bit positions, opcodes and counts of the data flag branch unit
//
// Overview of operation
// - monitor entry points from registers 3-6/6-C
// - 32-bit register one access is undefined
// - monitor-to-job exchange: store at zero, load page
// - zero page base makes both files identical
// - job-to-monitor: store back, reload monitor there
// - branch: finish, save next address, jump via 02
// - flag may come from earlier instructions
// - flags 35-47 are sticky
// - flags cleared only by 32 or 3B
// - flag 36 set only by interval timer
// - non-permissive control vector elements raise nothing
// - mask 19-31 written only by 33/3B
// - flags set regardless of mask
// - product bits are flag AND mask
// - bit 51 is OR of products
// - branch when 51 and 52 set
// - branch clears 52; 32/3B re-enable
// - flag 40 is OR of 37-39
`ifndef DFB_CONSTS_SVH
`define DFB_CONSTS_SVH
`define DFB_NFLAG 13
`define DFB_PROD_LO 3
`define DFB_MASK_LO 19
`define DFB_FLAG_LO 35
`define DFB_FLAG_HI 47
`define DFB_OR_BIT 51
`define DFB_EN_BIT 52
`define DFB_TIMER_IDX 1
`define DFB_SUM_IDX 5
`define DFB_OPC_ALTER 8'h32
`define DFB_OPC_MASK 8'h33
`define DFB_OPC_LDST 8'h3b
`define DFB_REG_EXIT 4'h1
`define DFB_REG_ENTRY 4'h2
`define DFB_MON_BASE64 4'h3
`define DFB_MON_BASE32 4'h6
`define DFB_RF_WORDS 256
`define DFB_WORD_SHIFT 6
`define DFB_PAGE_BITS 15
`endif

// *** dfb_pkg.sv ***
// types shared by the data flag branch unit
package dfb_pkg;
	typedef enum logic [1:0] {ENT_UNDEF, ENT_EXIT_FORCE, ENT_EXT_INT, ENT_STORAGE} dfb_entry_t;
	typedef enum {XS_IDLE, XS_STORE, XS_LOAD, XS_DONE} dfb_xstate_t;
	typedef struct packed {
		logic valid;
		logic [7:0] code;
		logic load;
		logic [5:0] bit_sel;
		logic [63:0] value;
	} dfb_op_t;
	typedef struct packed {
		logic valid;
		logic [12:0] bits;
		logic cv_active;
		logic cv_perm;
	} dfb_cond_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] word;
		logic [47:0] addr;
	} dfb_mem_t;
endpackage

// *** dfb_unit.sv ***
// data flag branch register, branch sequencing and register file exchange
`timescale 1ns/10ps
`default_nettype none
`include "dfb_consts.svh"

module dfb_unit
	import dfb_pkg::*;
#(
	parameter int ADDR_W = 48
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire dfb_cond_t cond,
	input wire logic timer_tick,
	input wire dfb_op_t op,
	input wire logic instr_done,
	input wire logic [ADDR_W-1:0] next_addr,
	input wire logic [ADDR_W-1:0] entry_reg_addr,
	output logic branch_take,
	output logic [ADDR_W-1:0] branch_target,
	output logic rf_wr_en,
	output logic [3:0] rf_wr_idx,
	output logic [ADDR_W-1:0] rf_wr_data,
	output logic [63:0] dfb_rd_data,
	output logic alter_old_bit,
	input wire dfb_entry_t entry_kind,
	input wire logic mode32,
	output logic [3:0] entry_idx,
	input wire logic acc_valid,
	input wire logic acc_mode32,
	input wire logic [3:0] acc_idx,
	output logic acc_undef,
	input wire logic xchg_start,
	input wire logic xchg_to_job,
	input wire logic xchg_s_zero,
	input wire logic [ADDR_W-1:0] page_base,
	output dfb_mem_t mem_req,
	input wire logic mem_ready,
	output logic xchg_busy,
	output logic xchg_done
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// byte-free bit address of one register file word
	function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] base,
		input logic [7:0] idx);
		word_addr = base + (ADDR_W'(idx) << `DFB_WORD_SHIFT);
	endfunction

	// monitor entry register for an event, in 64- or 32-bit numbering
	function automatic logic [3:0] entry_reg(input dfb_entry_t k, input logic m32);
		logic [3:0] off;
		off = {2'h0, k};
		if (m32)
			entry_reg = `DFB_MON_BASE32 + (off << 1);
		else
			entry_reg = `DFB_MON_BASE64 + off;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register fields

	logic [12:0] flag_r;
	logic [12:0] mask_r;
	logic en_r;
	logic [12:0] flag_eff;
	logic [12:0] product;
	logic any_product;
	logic [12:0] flag_set;
	logic op_alter, op_mask, op_load, op_store;
	logic alter_in_flags;
	logic [3:0] alter_idx;
	logic branch_now;

	assign op_alter = op.valid && op.code == `DFB_OPC_ALTER;
	assign op_mask = op.valid && op.code == `DFB_OPC_MASK;
	assign op_load = op.valid && op.code == `DFB_OPC_LDST && op.load;
	assign op_store = op.valid && op.code == `DFB_OPC_LDST && !op.load;
	assign alter_in_flags = op.bit_sel >= 6'(`DFB_FLAG_LO) && op.bit_sel <= 6'(`DFB_FLAG_HI);
	assign alter_idx = 4'(op.bit_sel - 6'(`DFB_FLAG_LO));

	// gated event bits; the timer alone drives flag 36, so instructions cannot
	always_comb
	begin
		flag_set = '0;
		if (cond.valid && (!cond.cv_active || cond.cv_perm))
			flag_set = cond.bits & ~(13'h1 << `DFB_TIMER_IDX);
		if (timer_tick)
			flag_set[`DFB_TIMER_IDX] = 1'b1;
	end

	// sticky flags; an event in the cycle of a clear still lands
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			flag_r <= '0;
		else if (op_load)
			flag_r <= op.value[`DFB_FLAG_HI:`DFB_FLAG_LO] | flag_set;
		else if (op_alter && alter_in_flags)
		begin
			flag_r <= flag_r | flag_set;
			flag_r[alter_idx] <= op.value[0] | flag_set[alter_idx];
		end
		else
			flag_r <= flag_r | flag_set;
	end

	// mask field only moves on 33 or a 3B load
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			mask_r <= '0;
		else if (op_mask || op_load)
			mask_r <= op.value[`DFB_MASK_LO+12:`DFB_MASK_LO];
	end

	// summary flag 40 follows 37..39 continuously
	always_comb
	begin
		flag_eff = flag_r;
		flag_eff[`DFB_SUM_IDX] = flag_r[`DFB_SUM_IDX] | (|flag_r[4:2]);
	end

	// same index in all three fields keeps the triples aligned
	assign product = flag_eff & mask_r;
	assign any_product = |product;

	// a flag raised several instructions back still branches at this boundary
	assign branch_now = instr_done && any_product && en_r;

	// enable: branch clears it, a 32 or a 3B load rewrites it (rewrite wins)
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			en_r <= 1'b0;
		else if (op_load)
			en_r <= op.value[`DFB_EN_BIT];
		else if (op_alter)
			en_r <= 1'b1;
		else if (branch_now)
			en_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// branch sequencing

	// save return address in register 01 and jump to register 02
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			branch_take <= 1'b0;
			branch_target <= '0;
			rf_wr_en <= 1'b0;
			rf_wr_idx <= '0;
			rf_wr_data <= '0;
		end
		else
		begin
			branch_take <= branch_now;
			rf_wr_en <= branch_now;
			if (branch_now)
			begin
				branch_target <= entry_reg_addr;
				rf_wr_idx <= `DFB_REG_EXIT;
				rf_wr_data <= next_addr;
			end
		end
	end

	// whole-register image for 3B stores and the alter old-bit answer
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dfb_rd_data <= '0;
			alter_old_bit <= 1'b0;
		end
		else
		begin
			if (op_store)
			begin
				dfb_rd_data <= '0;
				dfb_rd_data[`DFB_PROD_LO+12:`DFB_PROD_LO] <= product;
				dfb_rd_data[`DFB_MASK_LO+12:`DFB_MASK_LO] <= mask_r;
				dfb_rd_data[`DFB_FLAG_HI:`DFB_FLAG_LO] <= flag_eff;
				dfb_rd_data[`DFB_OR_BIT] <= any_product;
				dfb_rd_data[`DFB_EN_BIT] <= en_r;
			end
			if (op_alter)
				alter_old_bit <= alter_in_flags ? flag_eff[alter_idx] : 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register file restrictions

	// combinational lookup, the execution unit samples it with the event
	assign entry_idx = entry_reg(entry_kind, mode32);

	// 32-bit register one overlaps register zero; result is not defined
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			acc_undef <= 1'b0;
		else
			acc_undef <= acc_valid && acc_mode32 && acc_idx == 4'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// exchange sequencer

	dfb_xstate_t xs_r;
	logic [7:0] word_r;
	logic [ADDR_W-1:0] store_base_r;
	logic [ADDR_W-1:0] load_base_r;
	logic [ADDR_W-1:0] job_base_r;
	logic [ADDR_W-1:0] job_page;
	logic mem_fire;

	// low page bits are dropped, so a save area always starts on a page
	assign job_page = (xchg_s_zero || page_base == '0) ? '0 :
		(page_base >> `DFB_PAGE_BITS) << `DFB_PAGE_BITS;
	assign mem_fire = mem_req.valid && mem_ready;

	// store all 256 words, then load all 256 words
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			xs_r <= XS_IDLE;
			word_r <= '0;
			store_base_r <= '0;
			load_base_r <= '0;
			job_base_r <= '0;
		end
		else
		begin
			unique case (xs_r)
				XS_IDLE:
					if (xchg_start)
					begin
						xs_r <= XS_STORE;
						word_r <= '0;
						if (xchg_to_job)
						begin
							store_base_r <= '0;
							load_base_r <= job_page;
							job_base_r <= job_page;
						end
						else
						begin
							store_base_r <= job_base_r;
							load_base_r <= job_base_r;
						end
					end
				// both phases walk the same 256 words, only the next state differs
				XS_STORE, XS_LOAD:
					if (mem_fire)
					begin
						word_r <= word_r + 8'h1;
						if (word_r == 8'(`DFB_RF_WORDS - 1))
							xs_r <= (xs_r == XS_STORE) ? XS_LOAD : XS_DONE;
					end
				XS_DONE:
					xs_r <= XS_IDLE;
			endcase
		end
	end

	// request is a pure function of state so it holds steady while stalled
	always_comb
	begin
		mem_req.valid = xs_r == XS_STORE || xs_r == XS_LOAD;
		mem_req.write = xs_r == XS_STORE;
		mem_req.word = word_r;
		mem_req.addr = word_addr(xs_r == XS_STORE ? store_base_r : load_base_r, word_r);
	end

	assign xchg_busy = xs_r != XS_IDLE;
	assign xchg_done = xs_r == XS_DONE;

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_branch_cause;
		instr_done && any_product && en_r && !op_load && !op_alter;
	endsequence
	sequence s_branch_effect;
		branch_take && rf_wr_en && rf_wr_idx == `DFB_REG_EXIT;
	endsequence
	property p_branch_seq;
		@(posedge clock) disable iff (!reset_n)
		s_branch_cause |=> s_branch_effect ##0 !en_r;
	endproperty
	a_branch_seq: assert property (p_branch_seq) else $error("branch not taken as expected");
	property p_no_branch_disabled;
		@(posedge clock) disable iff (!reset_n)
		!$past(en_r) |-> !branch_take;
	endproperty
	a_no_branch_disabled: assert property (p_no_branch_disabled) else $error("branch while disabled");
	property p_flag_sticky;
		@(posedge clock) disable iff (!reset_n)
		!op_load && !op_alter |=> (flag_r & $past(flag_r)) == $past(flag_r);
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without 32 or 3B");
	property p_flag_sets;
		@(posedge clock) disable iff (!reset_n)
		cond.valid && !cond.cv_active && cond.bits[2] |=> flag_r[2];
	endproperty
	a_flag_sets: assert property (p_flag_sets) else $error("flag 37 not set by event");
	// a refused element must leave every flag where it was
	property p_perm_gate;
		@(posedge clock) disable iff (!reset_n)
		cond.valid && cond.cv_active && !cond.cv_perm && !timer_tick && !op_load
			&& !op_alter |=> flag_r == $past(flag_r);
	endproperty
	a_perm_gate: assert property (p_perm_gate) else $error("non-permissive element set flag");
	property p_timer_only;
		@(posedge clock) disable iff (!reset_n)
		!flag_r[1] && !timer_tick && !op_load && !op_alter |=> !flag_r[1];
	endproperty
	a_timer_only: assert property (p_timer_only) else $error("flag 36 set without timer");
	property p_mask_hold;
		@(posedge clock) disable iff (!reset_n)
		!op_mask && !op_load |=> $stable(mask_r);
	endproperty
	a_mask_hold: assert property (p_mask_hold) else $error("mask changed without 33 or 3B");
	property p_summary;
		@(posedge clock) disable iff (!reset_n)
		flag_r[3] && mask_r[5] |-> any_product;
	endproperty
	a_summary: assert property (p_summary) else $error("flag 40 product missing");
	property p_entry64;
		@(posedge clock) disable iff (!reset_n)
		!mode32 && entry_kind == ENT_EXIT_FORCE |-> entry_idx == 4'h4;
	endproperty
	a_entry64: assert property (p_entry64) else $error("wrong exit force entry register");
	property p_acc_undef;
		@(posedge clock) disable iff (!reset_n)
		acc_valid && acc_mode32 && acc_idx == 4'h1 |=> acc_undef;
	endproperty
	a_acc_undef: assert property (p_acc_undef) else $error("register one access not flagged");
	property p_to_job_store_zero;
		@(posedge clock) disable iff (!reset_n)
		xs_r == XS_IDLE && xchg_start && xchg_to_job |=> mem_req.valid && mem_req.write
			&& mem_req.addr == '0;
	endproperty
	a_to_job_store_zero: assert property (p_to_job_store_zero) else $error("monitor save not at zero");
	property p_overlap;
		@(posedge clock) disable iff (!reset_n)
		xs_r == XS_IDLE && xchg_start && xchg_to_job && xchg_s_zero |=> load_base_r == '0;
	endproperty
	a_overlap: assert property (p_overlap) else $error("zero page base not overlapping");
	property p_back_to_monitor;
		@(posedge clock) disable iff (!reset_n)
		xs_r == XS_IDLE && xchg_start && !xchg_to_job |=> store_base_r == job_base_r
			&& load_base_r == job_base_r;
	endproperty
	a_back_to_monitor: assert property (p_back_to_monitor) else $error("job save area wrong");
endmodule

`default_nettype wire

// *** dfb_mem_model.sv ***
// memory responder for register file exchange traffic
`timescale 1ns/10ps
`default_nettype none
module dfb_mem_model
	import dfb_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire dfb_mem_t mem_req,
	input wire logic slow,
	output logic mem_ready,
	output logic [47:0] wr_base,
	output logic [47:0] rd_base,
	output logic [15:0] n_wr,
	output logic [15:0] n_rd,
	output logic addr_err
);
	logic [47:0] cur_r;
	////////////////////////////////////////
	// slow mode accepts every other cycle, so the sequencer must hold its request
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mem_ready <= 1'b0;
			{wr_base, rd_base, cur_r, n_wr, n_rd, addr_err} <= '0;
		end
		else
		begin
			mem_ready <= slow ? ~mem_ready : 1'b1;
			if (mem_req.valid && mem_ready)
			begin
				if (mem_req.word == 8'h00)
					cur_r <= mem_req.addr;
				else if (mem_req.addr !== cur_r + 48'({mem_req.word, 6'h00}))
					addr_err <= 1'b1; // words must sit 64 bits apart
				if (mem_req.write && mem_req.word == 8'h00)
					wr_base <= mem_req.addr;
				if (!mem_req.write && mem_req.word == 8'h00)
					rd_base <= mem_req.addr;
				n_wr <= n_wr + {15'h0, mem_req.write};
				n_rd <= n_rd + {15'h0, !mem_req.write};
			end
		end
	end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the data flag branch unit
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import dfb_pkg::*;
;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	dfb_cond_t cond = '0;
	dfb_op_t op = '0;
	dfb_entry_t entry_kind = ENT_UNDEF;
	logic timer_tick = 1'b0, instr_done = 1'b0, mode32 = 1'b0, slow = 1'b0;
	logic acc_valid = 1'b0, acc_mode32 = 1'b0, xchg_start = 1'b0, xchg_to_job = 1'b0;
	logic xchg_s_zero = 1'b0;
	logic [3:0] acc_idx = 4'h0;
	logic [47:0] next_addr = '0, page_base = '0;
	logic [47:0] entry_reg_addr = 48'h0000_00ab_c000; // register 02 contents
	logic branch_take, rf_wr_en, alter_old_bit, acc_undef, xchg_busy, xchg_done;
	logic mem_ready, addr_err;
	logic [3:0] rf_wr_idx, entry_idx;
	logic [47:0] branch_target, rf_wr_data, wr_base, rd_base;
	logic [63:0] dfb_rd_data;
	logic [15:0] n_wr, n_rd;
	dfb_mem_t mem_req;
	int err_count = 0;
	int n_tests = 0;

	dfb_unit dfb_unit_inst (.clock(clock), .reset_n(reset_n), .cond(cond),
		.timer_tick(timer_tick), .op(op), .instr_done(instr_done), .next_addr(next_addr),
		.entry_reg_addr(entry_reg_addr), .branch_take(branch_take),
		.branch_target(branch_target), .rf_wr_en(rf_wr_en), .rf_wr_idx(rf_wr_idx),
		.rf_wr_data(rf_wr_data), .dfb_rd_data(dfb_rd_data), .alter_old_bit(alter_old_bit),
		.entry_kind(entry_kind), .mode32(mode32), .entry_idx(entry_idx),
		.acc_valid(acc_valid), .acc_mode32(acc_mode32), .acc_idx(acc_idx),
		.acc_undef(acc_undef), .xchg_start(xchg_start), .xchg_to_job(xchg_to_job),
		.xchg_s_zero(xchg_s_zero), .page_base(page_base), .mem_req(mem_req),
		.mem_ready(mem_ready), .xchg_busy(xchg_busy), .xchg_done(xchg_done));
	dfb_mem_model dfb_mem_model_inst (.clock(clock), .reset_n(reset_n), .mem_req(mem_req),
		.slow(slow), .mem_ready(mem_ready), .wr_base(wr_base), .rd_base(rd_base),
		.n_wr(n_wr), .n_rd(n_rd), .addr_err(addr_err));

	////////////////////////////////////////
	// 250 MHz clock
	always #2 clock = ~clock;

	task automatic tally_and_finish();
		$display("TB: errors=%0d checks=%0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [63:0] b(input int n);
		return 64'h1 << n;
	endfunction
	// one flag instruction, taken at the second edge
	task automatic do_op(input logic [7:0] c, input logic ld, input logic [5:0] s, input logic [63:0] v);
		@(posedge clock);
		op <= '{1'b1, c, ld, s, v};
		@(posedge clock);
		op.valid <= 1'b0;
	endtask
	// store the register image; readback lands one edge after the store
	task automatic rd_chk(input logic [63:0] exp);
		do_op(8'h3b, 1'b0, 6'h00, 64'h0);
		@(posedge clock);
		@(negedge clock);
		check(dfb_rd_data, exp);
	endtask
	task automatic raise(input logic [12:0] bits, input logic act, input logic perm);
		@(posedge clock);
		cond <= '{1'b1, bits, act, perm};
		@(posedge clock);
		cond.valid <= 1'b0;
	endtask
	task automatic boundary(input logic [47:0] na, input logic take);
		@(posedge clock);
		instr_done <= 1'b1;
		next_addr <= na;
		@(posedge clock);
		instr_done <= 1'b0;
		@(negedge clock);
		check(branch_take, take);
		if (take)
		begin
			check({rf_wr_en, rf_wr_idx, rf_wr_data}, {1'b1, 4'h1, na});
			check(branch_target, entry_reg_addr);
		end
	endtask
	task automatic xchg(input logic tj, input logic sz, input logic [47:0] pb,
		input logic [47:0] ew, input logic [47:0] er);
		logic [15:0] w0, r0;
		w0 = n_wr;
		r0 = n_rd;
		@(posedge clock);
		{xchg_start, xchg_to_job, xchg_s_zero, page_base, slow} <= {1'b1, tj, sz, pb, tj};
		@(posedge clock);
		xchg_start <= 1'b0;
		for (int i = 0; i < 3000 && xchg_done !== 1'b1; i++)
			@(negedge clock);
		check(xchg_done, 1'b1);
		check(xchg_busy, 1'b1);
		@(negedge clock);
		check(xchg_busy, 1'b0);
		check(wr_base, ew);
		check(rd_base, er);
		check({n_wr - w0, n_rd - r0, 15'h0, addr_err}, {16'd256, 16'd256, 16'h0});
	endtask

	////////////////////////////////////////
	// watchdog, far beyond the roughly 3700 cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clock);
		err_count++;
		tally_and_finish();
	end

	// main sequence
	initial
	begin
		logic [63:0] e;
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		do_op(8'h3b, 1'b1, 6'h00, b(52));
		raise(13'h0004, 1'b0, 1'b0);
		rd_chk(b(52) | b(40) | b(37));
		do_op(8'h33, 1'b0, 6'h00, b(21));
		rd_chk(b(52) | b(51) | b(40) | b(37) | b(21) | b(5));
		boundary(48'h0000_0000_1230, 1'b1);
		rd_chk(b(51) | b(40) | b(37) | b(21) | b(5));
		boundary(48'h0000_0000_1240, 1'b0);
		raise(13'h0040, 1'b1, 1'b0);
		raise(13'h0002, 1'b0, 1'b0);
		rd_chk(b(51) | b(40) | b(37) | b(21) | b(5));
		raise(13'h0040, 1'b1, 1'b1);
		@(posedge clock);
		timer_tick <= 1'b1;
		@(posedge clock);
		timer_tick <= 1'b0;
		rd_chk(b(51) | b(41) | b(40) | b(37) | b(36) | b(21) | b(5));
		do_op(8'h32, 1'b0, 6'd36, 64'h0);
		@(posedge clock);
		@(negedge clock);
		check(alter_old_bit, 1'b1);
		rd_chk(b(52) | b(51) | b(41) | b(40) | b(37) | b(21) | b(5));
		boundary(48'h0000_0000_5670, 1'b1);
		do_op(8'h3b, 1'b1, 6'h00, 64'h0);
		rd_chk(64'h0);
		do_op(8'h33, 1'b0, 6'h00, ~64'h0);
		rd_chk(64'h0000_0000_fff8_0000);
		raise(13'h1ffd, 1'b0, 1'b0);
		e = 64'h0000_0000_fff8_0000 | b(51);
		for (int i = 0; i < 13; i++)
			if (i != 1)
				e = e | b(35 + i) | b(3 + i);
		rd_chk(e);
		// alter aimed outside the flag field only re-enables branching
		do_op(8'h32, 1'b0, 6'd20, 64'h1);
		@(posedge clock);
		@(negedge clock);
		check(alter_old_bit, 1'b0);
		rd_chk(e | b(52));
		// entry point table for both register widths
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clock);
			entry_kind <= dfb_entry_t'(k[1:0]);
			mode32 <= k[2];
			@(negedge clock);
			check(entry_idx, k[2] ? 4'(6 + 2 * k[1:0]) : 4'(3 + k[1:0]));
		end
		// only the 32-bit view of register one is undefined
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clock);
			{acc_valid, acc_mode32, acc_idx} <= {1'b1, k != 2, (k == 1) ? 4'h2 : 4'h1};
			@(posedge clock);
			acc_valid <= 1'b0;
			@(negedge clock);
			check(acc_undef, k == 0);
		end
		xchg(1'b1, 1'b0, 48'h0000_0012_8000, 48'h0, 48'h0000_0012_8000);
		xchg(1'b0, 1'b0, 48'h0000_0034_0000, 48'h0000_0012_8000, 48'h0000_0012_8000);
		xchg(1'b1, 1'b1, 48'h0000_0012_8000, 48'h0, 48'h0);
		xchg(1'b1, 1'b0, 48'h0, 48'h0, 48'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
